// ===== gtp_port_logic.v
/*
 gtp_port_logic.v: general-purpose input / tally port logic, one slice per
 port: function select, edge or level qualification, timed outputs, manual
 override and trigger-source control towards the splice encoder core.
 Assumes decoder match and frame strobe are synchronous to clock_i and
 that port pins are asynchronous. Configuration is held by the caller.
*/
// Functional notes
// - unused function ignores input and polarity
// - tally mode: output on decoded splice match
// - general output driven from configuration only
// - general input level is reported
// - trigger mode requests splice message insertion
// - override mode replaces source until restored
// - reset-source mode restores source, edge only
// - falling polarity fires once high to low
// - rising polarity fires once low to high
// - active-high acts while input high
// - active-low acts while input low
// - read-only per-port present tally state
// - output pulse lasts configured frame count
// - manual override picks user or function source
// - manual high latches output high until reset; code holds it only while manual_enable_i stays high and the level is unchanged
// - manual low latches output low until reset; code holds it only while manual_enable_i stays high and the level is unchanged
`timescale 1ns/10ps
`default_nettype none
`include "gtp_defs.vh"

module gtp_port_logic #(
  parameter PORTS    = `GTP_NUM_PORTS,
  parameter PW_WIDTH = `GTP_PW_WIDTH
) (
  input  wire                  clock_i,
  input  wire                  reset_i,
  input  wire                  enable_i,
  input  wire                  frame_start_i,
  input  wire [PORTS-1:0]      pin_i,
  input  wire [3*PORTS-1:0]    function_i,
  input  wire [2*PORTS-1:0]    polarity_i,
  input  wire [PW_WIDTH*PORTS-1:0] pulse_width_i,
  input  wire [PORTS-1:0]      manual_enable_i,
  input  wire [PORTS-1:0]      manual_level_i,
  input  wire [PORTS-1:0]      general_out_i,
  input  wire [PORTS-1:0]      tally_match_i,
  input  wire                  source_edge_mode_i,
  output wire [PORTS-1:0]      pin_o,
  output wire [PORTS-1:0]      pin_oe_o,
  output wire [PORTS-1:0]      input_level_o,
  output wire [PORTS-1:0]      tally_state_o,
  output wire                  trigger_req_o,
  output wire [PORTS-1:0]      trigger_port_o,
  output reg                   source_override_o
);

  wire [PORTS-1:0] pin_sync;
  reg  [PORTS-1:0] pin_prev_q;
  wire [PORTS-1:0] qualify;
  wire [PORTS-1:0] is_level;
  wire [PORTS-1:0] fn_out;
  wire [PORTS-1:0] trig_pulse;
  wire [PORTS-1:0] ovr_set;
  wire [PORTS-1:0] ovr_clr;

  // pins are asynchronous to the core clock
  gtp_sync #(
    .WIDTH    (PORTS)
  ) u_sync (
    .clock_i  (clock_i),
    .reset_i  (reset_i),
    .enable_i (enable_i),
    .async_i  (pin_i),
    .sync_o   (pin_sync)
  );

  // previous synchronised level for edge detection
  always @(posedge clock_i)
  begin
    if (reset_i)
      pin_prev_q <= {PORTS{1'b1}};
    else if (enable_i)
      pin_prev_q <= pin_sync;
  end

  genvar g;
  generate
    for (g = 0; g < PORTS; g = g + 1)
    begin : g_port
      wire [2:0]          fn    = function_i[3*g +: 3];
      wire [1:0]          pol   = polarity_i[2*g +: 2];
      wire                now   = pin_sync[g];
      wire                was   = pin_prev_q[g];
      reg                 qual;
      wire                start;
      wire                pulse_on;
      reg                 latch_q;
      reg                 latch_set_q;
      reg                 man_prev_q;
      reg                 drive;
      reg                 oe;
      reg                 level_q;
      reg                 pin_q;
      reg                 oe_q;
      reg                 in_lvl_q;
      reg                 tally_q;
      reg                 trig_q;

      // polarity qualification; unused function disregards it
      always @*
      begin
        qual = 1'b0;
        if (fn != `GTP_FN_UNUSED)
        begin
          case (pol)
            `GTP_POL_FALLING: qual = was & ~now;
            `GTP_POL_RISING:  qual = ~was & now;
            `GTP_POL_HIGH:    qual = now;
            `GTP_POL_LOW:     qual = ~now;
            default:          qual = 1'b0;
          endcase
        end
      end
      assign qualify[g]  = qual;
      assign is_level[g] = pol[1];

      // tally and general output pulses start on their own event
      assign start = (fn == `GTP_FN_TALLY)   ? tally_match_i[g] :
                     (fn == `GTP_FN_GEN_OUT) ? general_out_i[g] :
                     1'b0;

      gtp_pulse #(
        .PW_WIDTH (PW_WIDTH)
      ) u_pulse (
        .clock_i  (clock_i),
        .reset_i  (reset_i),
        .enable_i (enable_i),
        .start_i  (start),
        .frame_i  (frame_start_i),
        .width_i  (pulse_width_i[PW_WIDTH*g +: PW_WIDTH]),
        .active_o (pulse_on)
      );
      assign fn_out[g] = pulse_on;

      // manual level latched on first enable after reset or on a level change while enabled
      always @(posedge clock_i)
      begin
        if (reset_i)
        begin
          latch_q     <= 1'b0;
          latch_set_q <= 1'b0;
          man_prev_q  <= 1'b0;
        end
        else if (enable_i)
        begin
          man_prev_q <= manual_level_i[g];
          if (manual_enable_i[g] &&
              (!latch_set_q || (man_prev_q != manual_level_i[g])))
          begin
            latch_set_q <= 1'b1;
            latch_q     <= manual_level_i[g];
          end
        end
      end

      // output source: user latch or function pulse; inverted manual level until the latch is set
      always @*
      begin
        oe    = (fn == `GTP_FN_TALLY) || (fn == `GTP_FN_GEN_OUT);
        drive = 1'b0;
        if (manual_enable_i[g])
        begin
          oe    = 1'b1;
          drive = latch_set_q ? latch_q : ~manual_level_i[g];
        end
        else if (oe)
          drive = fn_out[g];
      end

      // registered pin drive and reporting
      always @(posedge clock_i)
      begin
        if (reset_i)
        begin
          pin_q    <= 1'b0;
          oe_q     <= 1'b0;
          in_lvl_q <= 1'b0;
          tally_q  <= 1'b0;
          trig_q   <= 1'b0;
          level_q  <= 1'b0;
        end
        else if (enable_i)
        begin
          pin_q <= drive;
          oe_q  <= oe;
          // input level only reported in general input mode
          in_lvl_q <= (fn == `GTP_FN_GEN_IN) ? now : 1'b0;
          // tally reflects the pin drive when driving, else the input
          tally_q <= oe ? drive : now;
          // level modes request once per asserted period, avoiding floods
          level_q <= qualify[g];
          trig_q  <= (fn == `GTP_FN_TRIGGER) &&
                     (is_level[g] ? (qualify[g] & ~level_q) : qualify[g]);
        end
      end

      // per-slice flops keep every output bit on a single driver
      assign pin_o[g]         = pin_q;
      assign pin_oe_o[g]      = oe_q;
      assign input_level_o[g] = in_lvl_q;
      assign tally_state_o[g] = tally_q;
      assign trig_pulse[g]    = trig_q;

      assign ovr_set[g] = (fn == `GTP_FN_OVERRIDE) && qualify[g];
      assign ovr_clr[g] = (fn == `GTP_FN_SRC_RESET) && qualify[g] &&
                          source_edge_mode_i && !is_level[g];
    end
  endgenerate

  assign trigger_req_o  = |trig_pulse;
  assign trigger_port_o = trig_pulse;

  // override holds until a reset-source event; a set in the same cycle wins
  always @(posedge clock_i)
  begin
    if (reset_i)
      source_override_o <= 1'b0;
    else if (enable_i)
    begin
      if (|ovr_set)
        source_override_o <= 1'b1;
      else if (|ovr_clr)
        source_override_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== gtp_defs.vh
/*
 gtp_defs.vh: constants for the general-purpose input / tally port logic:
 function codes, polarity codes, reset values and timing.
 Assumes inclusion by bare name from each design file of the block.
*/
`ifndef GTP_DEFS_VH
`define GTP_DEFS_VH

// port function codes
`define GTP_FN_UNUSED     3'h0
`define GTP_FN_TALLY      3'h1
`define GTP_FN_GEN_OUT    3'h2
`define GTP_FN_TRIGGER    3'h3
`define GTP_FN_OVERRIDE   3'h4
`define GTP_FN_SRC_RESET  3'h5
`define GTP_FN_GEN_IN     3'h6

// trigger / tally polarity codes
`define GTP_POL_FALLING   2'h0
`define GTP_POL_RISING    2'h1
`define GTP_POL_HIGH      2'h2
`define GTP_POL_LOW       2'h3

// widths and reset values
`define GTP_NUM_PORTS     4
`define GTP_PW_WIDTH      8
`define GTP_PW_RESET      8'h01
`define GTP_SYNC_STAGES   2

`endif

// ===== gtp_sync.v
/*
 gtp_sync.v: multi-bit two-stage synchroniser for port pins.
 Assumes each bit is an independent asynchronous level.
*/
`timescale 1ns/10ps
`default_nettype none
`include "gtp_defs.vh"

module gtp_sync #(
  parameter WIDTH = `GTP_NUM_PORTS
) (
  input  wire             clock_i,
  input  wire             reset_i,
  input  wire             enable_i,
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] stable_q;

  // first stage feeds only the second stage
  always @(posedge clock_i)
  begin
    if (reset_i)
    begin
      meta_q   <= {WIDTH{1'b1}};
      stable_q <= {WIDTH{1'b1}};
    end
    else if (enable_i)
    begin
      meta_q   <= async_i;
      stable_q <= meta_q;
    end
  end

  assign sync_o = stable_q;

endmodule
`default_nettype wire

// ===== gtp_pulse.v
/*
 gtp_pulse.v: frame-counted output pulse timer.
 Assumes frame_i is a one-cycle frame-start strobe on clock_i.
*/
`timescale 1ns/10ps
`default_nettype none
`include "gtp_defs.vh"

module gtp_pulse #(
  parameter PW_WIDTH = `GTP_PW_WIDTH
) (
  input  wire                clock_i,
  input  wire                reset_i,
  input  wire                enable_i,
  input  wire                start_i,
  input  wire                frame_i,
  input  wire [PW_WIDTH-1:0] width_i,
  output wire                active_o
);

  reg [PW_WIDTH-1:0] count_q;
  reg                active_q;

  // restart wins over the frame decrement so a retrigger is never lost
  always @(posedge clock_i)
  begin
    if (reset_i)
    begin
      count_q  <= {PW_WIDTH{1'b0}};
      active_q <= 1'b0;
    end
    else if (enable_i)
    begin
      if (start_i && (width_i != {PW_WIDTH{1'b0}}))
      begin
        count_q  <= width_i;
        active_q <= 1'b1;
      end
      else if (active_q && frame_i)
      begin
        count_q <= count_q - {{(PW_WIDTH-1){1'b0}}, 1'b1};
        if (count_q == {{(PW_WIDTH-1){1'b0}}, 1'b1})
          active_q <= 1'b0;
      end
    end
  end

  assign active_o = active_q;

endmodule
`default_nettype wire

// ===== gtp_ext_equip.sv
/*
 gtp_ext_equip.sv: outside equipment wired to the four port pins.
 Assumes the port logic drives a pin only while its enable is high.
*/
`timescale 1ns/10ps
`default_nettype none
module gtp_ext_equip (
  input  wire logic [3:0] level_i,
  input  wire logic [3:0] oe_i,
  input  wire logic [3:0] out_i,
  output logic      [3:0] wire_o
);
  // device drive wins; otherwise the equipment holds its own level
  assign wire_o = (oe_i & out_i) | (~oe_i & level_i);
endmodule
`default_nettype wire

// ===== gtp_port_logic_sva.sv
/*
 gtp_port_logic_sva.sv: timing checks on port slice 0 of the port logic.
 Assumes four ports and 8-bit widths; checks pause while enable_i is low.
*/
`timescale 1ns/10ps
`default_nettype none
`include "gtp_defs.vh"
module gtp_port_logic_sva (
  input wire logic        clock_i,
  input wire logic        reset_i,
  input wire logic        enable_i,
  input wire logic        frame_start_i,
  input wire logic [3:0]  pin_i,
  input wire logic [11:0] function_i,
  input wire logic [7:0]  polarity_i,
  input wire logic [31:0] pulse_width_i,
  input wire logic [3:0]  manual_enable_i,
  input wire logic [3:0]  manual_level_i,
  input wire logic [3:0]  tally_match_i,
  input wire logic [3:0]  pin_o,
  input wire logic [3:0]  pin_oe_o,
  input wire logic [3:0]  input_level_o,
  input wire logic [3:0]  trigger_port_o
);
  default clocking @(posedge clock_i); endclocking
  // a frozen clock enable holds outputs, so timing checks rest meanwhile
  default disable iff (reset_i || !enable_i);
  // slice 0 mode shorthands
  wire trg0 = function_i[2:0] == `GTP_FN_TRIGGER;
  wire tal0 = function_i[2:0] == `GTP_FN_TALLY && !manual_enable_i[0];
  // pin edges must stay put two cycles to count
  sequence s_fall;
    trg0 && polarity_i[1:0] == `GTP_POL_FALLING && $fell(pin_i[0]) ##1 !pin_i[0] [*2];
  endsequence
  sequence s_rise;
    trg0 && polarity_i[1:0] == `GTP_POL_RISING && $rose(pin_i[0]) ##1 pin_i[0] [*2];
  endsequence
  sequence s_match;
    tal0 && tally_match_i[0] && pulse_width_i[7:0] != 8'h00 && !frame_start_i
    ##1 (tal0 && !frame_start_i) [*3];
  endsequence
  property p_fall; s_fall |-> ##[0:2] trigger_port_o[0]; endproperty
  a_fall: assert property (p_fall) else $error("no trigger on falling pin");
  property p_rise; s_rise |-> ##[0:2] trigger_port_o[0]; endproperty
  a_rise: assert property (p_rise) else $error("no trigger on rising pin");
  property p_one; trigger_port_o[0] |=> !trigger_port_o[0]; endproperty
  a_one: assert property (p_one) else $error("trigger longer than one cycle");
  property p_pon; s_match |-> pin_o[0] && pin_oe_o[0]; endproperty
  a_pon: assert property (p_pon) else $error("tally pulse did not start");
  // a pulse may only end two or three edges after a frame strobe
  property p_poff;
    tal0 [*4] ##0 $fell(pin_o[0]) |-> $past(frame_start_i, 2) || $past(frame_start_i, 3);
  endproperty
  a_poff: assert property (p_poff) else $error("pulse ended off a frame");
  property p_moe; manual_enable_i[0] [*3] |-> pin_oe_o[0]; endproperty
  a_moe: assert property (p_moe) else $error("manual mode not driving");
  property p_mlvl;
    (manual_enable_i[0] && $stable(manual_level_i[0])) [*3] |-> pin_o[0] == manual_level_i[0];
  endproperty
  a_mlvl: assert property (p_mlvl) else $error("manual level not shown");
  property p_gin;
    (function_i[2:0] == `GTP_FN_GEN_IN && $stable(pin_i[0])) [*4] |-> input_level_o[0] == pin_i[0];
  endproperty
  a_gin: assert property (p_gin) else $error("input level not reported");
endmodule
bind gtp_port_logic gtp_port_logic_sva u_sva (
  .clock_i         (clock_i),
  .reset_i         (reset_i),
  .enable_i        (enable_i),
  .frame_start_i   (frame_start_i),
  .pin_i           (pin_i),
  .function_i      (function_i),
  .polarity_i      (polarity_i),
  .pulse_width_i   (pulse_width_i),
  .manual_enable_i (manual_enable_i),
  .manual_level_i  (manual_level_i),
  .tally_match_i   (tally_match_i),
  .pin_o           (pin_o),
  .pin_oe_o        (pin_oe_o),
  .input_level_o   (input_level_o),
  .trigger_port_o  (trigger_port_o)
);
`default_nettype wire

// ===== gtp_port_logic_tb.sv
/*
 gtp_port_logic_tb.sv: directed test of the port logic by pin, match and
 manual calls. Assumes the outside equipment model sits on the pins.
*/
`timescale 1ns/10ps
`default_nettype none
`include "gtp_defs.vh"
module gtp_port_logic_tb;
  logic        clock_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        enable_i = 1'b1;
  logic        frame_start_i = 1'b0;
  logic        source_edge_mode_i = 1'b1;
  logic [3:0]  ext = 4'hF;
  logic [11:0] function_i = 12'h000;
  logic [7:0]  polarity_i = 8'h00;
  logic [31:0] pulse_width_i = 32'h03030303;
  logic [3:0]  manual_enable_i = 4'h0;
  logic [3:0]  manual_level_i = 4'h0;
  logic [3:0]  general_out_i = 4'h0;
  logic [3:0]  tally_match_i = 4'h0;
  wire  [3:0]  pin_i, pin_o, pin_oe_o, input_level_o, tally_state_o, trigger_port_o;
  wire         trigger_req_o, source_override_o;
  integer      bad_count = 0, total_checks = 0, cyc = 0, trig_cnt = 0, fr_cnt = 0, i;
  integer      req_cnt = 0;
  always #2.5 clock_i = ~clock_i;
  gtp_port_logic DUT (
    .clock_i            (clock_i),
    .reset_i            (reset_i),
    .enable_i           (enable_i),
    .frame_start_i      (frame_start_i),
    .pin_i              (pin_i),
    .function_i         (function_i),
    .polarity_i         (polarity_i),
    .pulse_width_i      (pulse_width_i),
    .manual_enable_i    (manual_enable_i),
    .manual_level_i     (manual_level_i),
    .general_out_i      (general_out_i),
    .tally_match_i      (tally_match_i),
    .source_edge_mode_i (source_edge_mode_i),
    .pin_o              (pin_o),
    .pin_oe_o           (pin_oe_o),
    .input_level_o      (input_level_o),
    .tally_state_o      (tally_state_o),
    .trigger_req_o      (trigger_req_o),
    .trigger_port_o     (trigger_port_o),
    .source_override_o  (source_override_o)
  );
  gtp_ext_equip u_ext (.level_i(ext), .oe_i(pin_oe_o), .out_i(pin_o), .wire_o(pin_i));
  // frame strobe every ten cycles, event counts, hang limit
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    frame_start_i <= #1 (cyc % 10 == 9);
    if (trigger_port_o[0]) trig_cnt <= trig_cnt + 1;
    if (trigger_req_o) req_cnt <= req_cnt + 1;
    if (frame_start_i & pin_o[0]) fr_cnt <= fr_cnt + 1;
    if (cyc == 5000)
    begin
      bad_count = bad_count + 1;
      tally_and_finish;
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  // inputs move 1 ns after the edge, away from sampling
  task automatic step(input integer n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic pulse_pin(input integer p);
    ext[p] = 1'b0;
    step(6);
    ext[p] = 1'b1;
    step(6);
  endtask
  task automatic match0;
    while (cyc % 10 != 2) step(1);
    tally_match_i[0] = 1'b1;
    step(1);
    tally_match_i[0] = 1'b0;
    step(3);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    step(2);
    reset_i = 1'b0;
    pulse_pin(0);
    chk("unused trig", trig_cnt, 0);
    function_i[2:0] = `GTP_FN_TRIGGER;
    // every polarity: two active periods give two triggers
    for (i = 0; i < 4; i = i + 1)
    begin
      polarity_i[1:0] = i[1:0];
      ext[0] = ~(i[0] ^ i[1]);
      step(8);
      trig_cnt = 0;
      req_cnt = 0;
      repeat (4)
      begin
        ext[0] = ~ext[0];
        step(6);
      end
      chk("trig count", trig_cnt, 2);
      chk("req count", req_cnt, 2);
    end
    function_i[8:3] = {`GTP_FN_SRC_RESET, `GTP_FN_OVERRIDE};
    pulse_pin(1);
    chk("override", source_override_o, 1);
    pulse_pin(2);
    chk("restore", source_override_o, 0);
    pulse_pin(1);
    source_edge_mode_i = 1'b0;
    pulse_pin(2);
    chk("restore refused", source_override_o, 1);
    chk("override no trigger", req_cnt, 2);
    function_i[2:0] = `GTP_FN_TALLY;
    step(4);
    fr_cnt = 0;
    match0;
    chk("tally on", {pin_oe_o[0], pin_o[0], tally_state_o[0]}, 7);
    step(40);
    chk("frames", fr_cnt, 3);
    chk("tally off", {pin_o[0], tally_state_o[0]}, 0);
    pulse_width_i[7:0] = 8'h00;
    match0;
    step(3);
    chk("zero width", pin_o[0], 0);
    pulse_width_i[7:0] = 8'h03;
    function_i[2:0] = `GTP_FN_GEN_OUT;
    general_out_i[0] = 1'b1;
    step(1);
    general_out_i[0] = 1'b0;
    step(3);
    chk("general out", pin_o[0], 1);
    step(40);
    manual_enable_i[0] = 1'b1;
    step(4);
    chk("manual low", {pin_oe_o[0], pin_o[0]}, 2);
    manual_level_i[0] = 1'b1;
    step(4);
    chk("manual high", pin_o[0], 1);
    manual_enable_i[0] = 1'b0;
    step(4);
    chk("function drive", {pin_oe_o[0], pin_o[0]}, 2);
    function_i[2:0] = `GTP_FN_GEN_IN;
    step(6);
    ext[0] = 1'b0;
    step(2);
    chk("sync delay", input_level_o[0], 1);
    step(4);
    chk("input low", {pin_oe_o[0], input_level_o[0], tally_state_o[0]}, 0);
    // a low clock enable must freeze the reported level
    enable_i = 1'b0;
    ext[0] = 1'b1;
    step(6);
    chk("frozen level", input_level_o[0], 0);
    enable_i = 1'b1;
    step(4);
    chk("thawed level", input_level_o[0], 1);
    reset_i = 1'b1;
    step(2);
    chk("reset outs", {source_override_o, pin_oe_o, pin_o}, 0);
    reset_i = 1'b0;
    step(2);
    chk("level after reset", input_level_o[0], 1);
    tally_and_finish;
  end
endmodule
`default_nettype wire
